// ---- rtl/ismu_pkg.sv ----
package ismu_pkg;

   localparam int XLEN = 32;
   localparam int DLEN = 64;
   localparam int RIDX = 3;
   localparam int HALF = 16;
   localparam int BYTE = 8;

   // Operation codes supplied by the sequencer
   typedef enum logic [3:0] {
      ISMU_OP_NONE        = 4'b0000,
      ISMU_OP_SUB_HALF    = 4'b0001,
      ISMU_OP_SUB_WORD    = 4'b0010,
      ISMU_OP_SUB_DOUBLE  = 4'b0011,
      ISMU_OP_SUB_REG     = 4'b0100,
      ISMU_OP_SUB_MASKED  = 4'b0101,
      ISMU_OP_SUB_IMM     = 4'b0110,
      ISMU_OP_MUL_BYTE    = 4'b0111,
      ISMU_OP_MUL_HALF    = 4'b1000,
      ISMU_OP_MUL_WORD    = 4'b1001
   } ismu_op_e;

   typedef enum logic [1:0] {
      ISMU_ST_IDLE = 2'b00,
      ISMU_ST_LOW  = 2'b01,
      ISMU_ST_HIGH = 2'b10
   } ismu_state_e;

   localparam logic [RIDX-1:0] MASK_REG_IDX = 3'h4;

   localparam logic [XLEN-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [DLEN-1:0] DWORD_ZERO = 64'h0000_0000_0000_0000;

   // Condition flags
   typedef struct packed {
      logic exception;
      logic positive;
      logic negative;
      logic zero;
   } ismu_flags_s;

   // Request from the sequencer
   typedef struct packed {
      ismu_op_e        op;
      logic [RIDX-1:0] reg_r;
      logic [RIDX-1:0] reg_s;
      logic [XLEN-1:0] mem_lo;
      logic [XLEN-1:0] mem_hi;
      logic [XLEN-1:0] instr_word;
   } ismu_req_s;

endpackage

// ---- rtl/ismu_flag_eval.sv ----
`timescale 1ns/10ps
`default_nettype none

module ismu_flag_eval #(
   parameter int WIDTH = 64
) (
   input  wire logic [WIDTH-1:0] value_i,
   input  wire logic             exception_i,
   output var  ismu_pkg::ismu_flags_s flags_o
);

   always_comb begin
      flags_o.exception = exception_i;
      flags_o.negative  = value_i[WIDTH-1];
      flags_o.zero      = (value_i == '0);
      flags_o.positive  = !value_i[WIDTH-1] && (value_i != '0);
   end

endmodule

`default_nettype wire

// ---- rtl/ismu_core.sv ----
// Overview of operation
// - Halfword memory operand is sign extended
// - Register minus halfword back into register
// - Register minus memory word into register
// - Doubleword: low word first, high with borrow
// - Destination minus source into destination
// - Masked difference ANDed with mask register
// - Immediate low halfword sign extended, subtracted
// - Memory byte zero extended for multiply
// - Operand times signed register R+1
// - Product high in R, low in R+1
// - Multiply clears exception flag always
// - Subtract sets exception flag on overflow
// - One of positive, negative, zero set
// - Multiply flags from 64-bit pair
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module ismu_core #(
   parameter int NREG = 8
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          start_i,
   input  wire ismu_pkg::ismu_req_s           req_i,
   input  wire logic                          reg_wr_en_i,
   input  wire logic [ismu_pkg::RIDX-1:0]     reg_wr_idx_i,
   input  wire logic [ismu_pkg::XLEN-1:0]     reg_wr_data_i,
   input  wire logic [ismu_pkg::RIDX-1:0]     reg_rd_idx_i,
   input  wire logic                          irq_clear_i,
   input  wire logic                          irq_mask_i,
   output      logic [ismu_pkg::XLEN-1:0]     reg_rd_data_o,
   output      logic                          busy_o,
   output      logic                          done_o,
   output var  ismu_pkg::ismu_flags_s         cond_flags_o,
   output      logic                          irq_o
);

   typedef struct packed {
      ismu_pkg::ismu_state_e        state;
      ismu_pkg::ismu_req_s          req;
      logic [ismu_pkg::XLEN-1:0]    lo_word;
      logic                         borrow;
      logic [NREG-1:0][ismu_pkg::XLEN-1:0] general_register;
      logic [ismu_pkg::XLEN-1:0]    rd_data;
      logic                         busy;
      logic                         done;
      ismu_pkg::ismu_flags_s        flags;
      logic                         exc_status;
      logic                         exc_mask;
      logic                         irq;
   } ismu_core_s;

   ismu_core_s cur;
   ismu_core_s next_cur;

   logic [ismu_pkg::XLEN-1:0] res_word;
   logic [ismu_pkg::DLEN-1:0] res_dword;
   logic [ismu_pkg::DLEN-1:0] flag_val;
   logic                      res_exc;
   logic                      is_mul;
   ismu_pkg::ismu_flags_s     eval_flags;

   // Sign extend a halfword
   function automatic logic [ismu_pkg::XLEN-1:0] sext_half(
      input logic [ismu_pkg::HALF-1:0] h);
      sext_half = {{ismu_pkg::HALF{h[ismu_pkg::HALF-1]}}, h};
   endfunction

   // Signed overflow of a - b
   function automatic logic sub_ovf(input logic sa, input logic sb, input logic sr);
      sub_ovf = (sa != sb) && (sr != sa);
   endfunction

   function automatic logic [ismu_pkg::RIDX-1:0] pair_idx(
      input logic [ismu_pkg::RIDX-1:0] r);
      pair_idx = r + 3'h1;
   endfunction

   // Word sign bit position and zero padding of a byte operand
   localparam int SGN  = ismu_pkg::XLEN - 1;
   localparam int ZPAD = ismu_pkg::XLEN - ismu_pkg::BYTE;

   logic [ismu_pkg::XLEN-1:0] op_r;
   logic [ismu_pkg::XLEN-1:0] op_s;
   logic [ismu_pkg::XLEN-1:0] op_r1;
   logic [ismu_pkg::XLEN-1:0] mul_opnd;
   logic [ismu_pkg::XLEN-1:0] diff_rs;
   logic [ismu_pkg::XLEN:0]   diff_lo;
   logic [ismu_pkg::XLEN-1:0] diff_hi;

   always_comb begin
      op_r     = cur.general_register[cur.req.reg_r];
      op_s     = cur.general_register[cur.req.reg_s];
      op_r1    = cur.general_register[pair_idx(cur.req.reg_r)];
      mul_opnd = cur.req.mem_lo;
      res_word = ismu_pkg::WORD_ZERO;
      res_exc  = 1'b0;
      is_mul   = 1'b0;
      diff_rs  = op_r - op_s;
      diff_lo  = {1'b0, op_r1} - {1'b0, cur.req.mem_lo};
      diff_hi  = op_r - cur.req.mem_hi - {{SGN{1'b0}}, cur.borrow};
      case (cur.req.op)
         ismu_pkg::ISMU_OP_SUB_HALF: begin
            res_word = op_r - sext_half(cur.req.mem_lo[ismu_pkg::HALF-1:0]);
            res_exc  = sub_ovf(op_r[SGN], cur.req.mem_lo[ismu_pkg::HALF-1], res_word[SGN]);
         end
         ismu_pkg::ISMU_OP_SUB_WORD: begin
            res_word = op_r - cur.req.mem_lo;
            res_exc  = sub_ovf(op_r[SGN], cur.req.mem_lo[SGN], res_word[SGN]);
         end
         ismu_pkg::ISMU_OP_SUB_REG: begin
            res_word = diff_rs;
            res_exc  = sub_ovf(op_r[SGN], op_s[SGN], diff_rs[SGN]);
         end
         ismu_pkg::ISMU_OP_SUB_MASKED: begin
            res_word = diff_rs & cur.general_register[ismu_pkg::MASK_REG_IDX];
            res_exc  = sub_ovf(op_r[SGN], op_s[SGN], diff_rs[SGN]);
         end
         ismu_pkg::ISMU_OP_SUB_IMM: begin
            res_word = op_r - sext_half(cur.req.instr_word[ismu_pkg::HALF-1:0]);
            res_exc  = sub_ovf(op_r[SGN], cur.req.instr_word[ismu_pkg::HALF-1], res_word[SGN]);
         end
         ismu_pkg::ISMU_OP_MUL_BYTE: begin
            mul_opnd = {{ZPAD{1'b0}}, cur.req.mem_lo[ismu_pkg::BYTE-1:0]};
            is_mul   = 1'b1;
         end
         ismu_pkg::ISMU_OP_MUL_HALF: begin
            mul_opnd = sext_half(cur.req.mem_lo[ismu_pkg::HALF-1:0]);
            is_mul   = 1'b1;
         end
         ismu_pkg::ISMU_OP_MUL_WORD: begin
            is_mul   = 1'b1;
         end
         default: begin
            res_word = ismu_pkg::WORD_ZERO;
         end
      endcase
      res_dword = ismu_pkg::DLEN'($signed(mul_opnd)) * ismu_pkg::DLEN'($signed(op_r1));
   end

   always_comb begin
      if (is_mul) begin
         flag_val = res_dword;
      end else if (cur.req.op == ismu_pkg::ISMU_OP_SUB_DOUBLE) begin
         flag_val = {diff_hi, cur.lo_word};
      end else begin
         flag_val = {{ismu_pkg::XLEN{res_word[SGN]}}, res_word};
      end
   end

   logic exc_in;
   logic dbl_exc;

   assign dbl_exc = sub_ovf(op_r[SGN], cur.req.mem_hi[SGN], diff_hi[SGN]);
   assign exc_in  = is_mul ? 1'b0 :
                    (cur.req.op == ismu_pkg::ISMU_OP_SUB_DOUBLE) ? dbl_exc : res_exc;

   ismu_flag_eval #(
      .WIDTH (ismu_pkg::DLEN)
   ) u_flag_eval (
      .value_i     (flag_val),
      .exception_i (exc_in),
      .flags_o     (eval_flags)
   );

   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      case (cur.state)
         ismu_pkg::ISMU_ST_IDLE: begin
            if (start_i) begin
               next_cur.req   = req_i;
               next_cur.busy  = 1'b1;
               next_cur.state = (req_i.op == ismu_pkg::ISMU_OP_SUB_DOUBLE) ?
                                ismu_pkg::ISMU_ST_LOW : ismu_pkg::ISMU_ST_HIGH;
            end else if (reg_wr_en_i) begin
               next_cur.general_register[reg_wr_idx_i] = reg_wr_data_i;
            end
         end
         ismu_pkg::ISMU_ST_LOW: begin
            next_cur.lo_word = diff_lo[ismu_pkg::XLEN-1:0];
            next_cur.borrow  = diff_lo[ismu_pkg::XLEN];
            next_cur.state   = ismu_pkg::ISMU_ST_HIGH;
         end
         ismu_pkg::ISMU_ST_HIGH: begin
            if (is_mul) begin
               next_cur.general_register[cur.req.reg_r] = res_dword[ismu_pkg::DLEN-1:ismu_pkg::XLEN];
               next_cur.general_register[pair_idx(cur.req.reg_r)] = res_dword[ismu_pkg::XLEN-1:0];
            end else if (cur.req.op == ismu_pkg::ISMU_OP_SUB_DOUBLE) begin
               next_cur.general_register[cur.req.reg_r] = diff_hi;
               next_cur.general_register[pair_idx(cur.req.reg_r)] = cur.lo_word;
            end else if (cur.req.op != ismu_pkg::ISMU_OP_NONE) begin
               next_cur.general_register[cur.req.reg_r] = res_word;
            end
            next_cur.flags = eval_flags;
            if (eval_flags.exception) begin
               next_cur.exc_status = 1'b1;
            end
            next_cur.busy  = 1'b0;
            next_cur.done  = 1'b1;
            next_cur.state = ismu_pkg::ISMU_ST_IDLE;
         end
         default: begin
            next_cur.state = ismu_pkg::ISMU_ST_IDLE;
         end
      endcase
      // Sticky exception status, set wins over clear
      if (irq_clear_i && !(cur.state == ismu_pkg::ISMU_ST_HIGH && eval_flags.exception)) begin
         next_cur.exc_status = 1'b0;
      end
      next_cur.exc_mask = irq_mask_i;
      next_cur.irq      = next_cur.exc_status && next_cur.exc_mask;
      next_cur.rd_data  = cur.general_register[reg_rd_idx_i];
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rd_data_o = cur.rd_data;
   assign busy_o        = cur.busy;
   assign done_o        = cur.done;
   assign cond_flags_o  = cur.flags;
   assign irq_o         = cur.irq;

endmodule

`default_nettype wire

// ---- verif/ismu_core_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module ismu_core_properties (
   input wire logic                  core_clk_i,
   input wire logic                  sys_rst_i,
   input wire logic                  start_i,
   input wire ismu_pkg::ismu_req_s   req_i,
   input wire logic                  reg_wr_en_i,
   input wire logic [2:0]            reg_wr_idx_i,
   input wire logic [31:0]           reg_wr_data_i,
   input wire logic [2:0]            reg_rd_idx_i,
   input wire logic                  irq_clear_i,
   input wire logic                  irq_mask_i,
   input wire logic [31:0]           reg_rd_data_o,
   input wire logic                  busy_o,
   input wire logic                  done_o,
   input wire ismu_pkg::ismu_flags_s cond_flags_o,
   input wire logic                  irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic                take;
   ismu_pkg::ismu_req_s held;
   assign take = start_i && !busy_o;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         held <= '0;
      end else if (take) begin
         held <= req_i;
      end
   end
   chk_mul_exc_clear: assert property (
      done_o && held.op >= ismu_pkg::ISMU_OP_MUL_BYTE |-> !cond_flags_o.exception)
      else $error("multiply set exception");
   chk_sign_onehot: assert property (
      done_o |-> $onehot({cond_flags_o.positive, cond_flags_o.negative, cond_flags_o.zero}))
      else $error("sign flags not one-hot");
   chk_self_sub_zero: assert property (
      done_o && held.op == ismu_pkg::ISMU_OP_SUB_REG && held.reg_r == held.reg_s
      |-> cond_flags_o == 4'h1) else $error("self subtract not zero");
   chk_single_latency: assert property (
      take && req_i.op != ismu_pkg::ISMU_OP_SUB_DOUBLE |=> busy_o && !done_o ##1 done_o)
      else $error("single latency wrong");
   chk_double_latency: assert property (
      take && req_i.op == ismu_pkg::ISMU_OP_SUB_DOUBLE |=> busy_o [*2] ##1 done_o)
      else $error("double latency wrong");
   chk_flags_hold: assert property (
      !done_o |-> $stable(cond_flags_o)) else $error("flags moved without done");
   chk_done_pulse: assert property (
      done_o |=> !done_o) else $error("done too long");
   chk_busy_ends: assert property (
      done_o |-> !busy_o && $past(busy_o)) else $error("busy not ended");
   cover property (take && req_i.op == ismu_pkg::ISMU_OP_SUB_DOUBLE);
   cover property (done_o && cond_flags_o.exception);
   cover property (irq_o);
endmodule
`default_nettype wire

// ---- verif/ismu_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ismu_seq_model (
   input  wire logic                core_clk_i,
   input  wire logic                done_i,
   output var  ismu_pkg::ismu_req_s req_o,
   output      logic                start_o,
   output      logic                late_o
);
   initial begin
      req_o = '0;
      start_o = 1'b0;
      late_o = 1'b0;
   end
   task automatic issue(input ismu_pkg::ismu_req_s r, input int gap);
      int n;
      repeat (gap) @(posedge core_clk_i);
      if (r.op >= ismu_pkg::ISMU_OP_MUL_BYTE) begin
         r.reg_r[0] = 1'b0;
      end
      @(posedge core_clk_i);
      start_o <= 1'b1;
      req_o <= r;
      @(posedge core_clk_i);
      start_o <= 1'b0;
      req_o <= ismu_pkg::ismu_req_s'(~r);
      n = 0;
      while (!done_i && n < 8) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      late_o = !done_i;
   endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [31:0] Z = 32'h0000_0000;
   logic                  clk = 1'b0, rst = 1'b1, wen = 1'b0, iclr = 1'b0, imask = 1'b0;
   logic                  start, busy, done, late, irq;
   logic [2:0]            widx = 3'h0, ridx = 3'h0;
   logic [31:0]           wdat = Z, rdat;
   ismu_pkg::ismu_req_s   req;
   ismu_pkg::ismu_flags_s flags;
   int                    n_errors = 0, comparisons = 0;
   always #5 clk = ~clk;
   ismu_seq_model i_ismu_seq_model (.core_clk_i(clk), .done_i(done), .req_o(req),
      .start_o(start), .late_o(late));
   ismu_core i_ismu_core (.core_clk_i(clk), .sys_rst_i(rst), .start_i(start), .req_i(req),
      .reg_wr_en_i(wen), .reg_wr_idx_i(widx), .reg_wr_data_i(wdat), .reg_rd_idx_i(ridx),
      .irq_clear_i(iclr), .irq_mask_i(imask), .reg_rd_data_o(rdat), .busy_o(busy),
      .done_o(done), .cond_flags_o(flags), .irq_o(irq));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] i, input logic [31:0] d);
      @(posedge clk);
      wen <= 1'b1;
      widx <= i;
      wdat <= d;
      @(posedge clk);
      wen <= 1'b0;
      wdat <= ~d;
   endtask
   task automatic run(input ismu_pkg::ismu_op_e op, input logic [2:0] r, input logic [2:0] s,
                      input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] iw);
      i_ismu_seq_model.issue('{op, r, s, lo, hi, iw}, int'(r) % 3);
      if (late) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic reg_is(input logic [2:0] i, input logic [31:0] v);
      @(posedge clk);
      ridx <= i;
      repeat (2) @(posedge clk);
      #1 check(rdat, v);
   endtask
   task automatic mul(input ismu_pkg::ismu_op_e op, input logic [2:0] r, input logic [31:0] m,
                      input logic [31:0] b, input logic [63:0] p, input logic [3:0] f);
      wr(r | 3'h1, b);
      run(op, r, 3'h0, m, Z, Z);
      check(32'(flags), 32'(f));
      reg_is(r & 3'h6, p[63:32]);
      reg_is(r | 3'h1, p[31:0]);
   endtask
   task automatic t_sub_single();
      wr(3'h6, 32'h0002_4CB3);
      run(ismu_pkg::ISMU_OP_SUB_HALF, 3'h6, 3'h0, 32'h0000_34C6, Z, Z);
      reg_is(3'h6, 32'h0002_17ED);
      wr(3'h0, Z);
      run(ismu_pkg::ISMU_OP_SUB_HALF, 3'h0, 3'h0, 32'h0000_8000, Z, Z);
      reg_is(3'h0, 32'h0000_8000);
      wr(3'h1, 32'h00A6_264D);
      run(ismu_pkg::ISMU_OP_SUB_WORD, 3'h1, 3'h0, 32'h0007_4BC3, Z, Z);
      check(32'(flags), 32'h0000_0004);
      reg_is(3'h1, 32'h009E_DA8A);
      wr(3'h7, 32'hFFFF_839A);
      run(ismu_pkg::ISMU_OP_SUB_IMM, 3'h7, 3'h0, Z, Z, 32'hCB82_839A);
      reg_is(3'h7, Z);
   endtask
   task automatic t_sub_regs();
      wr(3'h1, 32'h1234_5678);
      wr(3'h2, 32'h1234_5678);
      run(ismu_pkg::ISMU_OP_SUB_REG, 3'h1, 3'h2, Z, Z, Z);
      check(32'(flags), 32'h0000_0001);
      reg_is(3'h1, Z);
      reg_is(3'h2, 32'h1234_5678);
      wr(3'h4, 32'h00FF_FF00);
      wr(3'h5, 32'h0007_4BC3);
      wr(3'h6, 32'h00A6_264D);
      run(ismu_pkg::ISMU_OP_SUB_MASKED, 3'h6, 3'h5, Z, Z, Z);
      reg_is(3'h6, 32'h009E_DA00);
      wr(3'h6, 32'h0000_0003);
      wr(3'h7, 32'h0000_0001);
      run(ismu_pkg::ISMU_OP_SUB_DOUBLE, 3'h6, 3'h0, 32'h8000_0002, 32'h0000_0001, Z);
      reg_is(3'h6, 32'h0000_0001);
      reg_is(3'h7, 32'h7FFF_FFFF);
      run(ismu_pkg::ISMU_OP_NONE, 3'h0, 3'h0, Z, Z, Z);
      check(32'(flags), 32'h0000_0001);
   endtask
   task automatic t_mul();
      mul(ismu_pkg::ISMU_OP_MUL_BYTE, 3'h0, 32'h0000_0080, 32'h6F90_C859,
          64'h0000_0037_C864_2C80, 4'h4);
      mul(ismu_pkg::ISMU_OP_MUL_HALF, 3'h3, 32'h0000_FFFD, 32'h0000_0003,
          64'hFFFF_FFFF_FFFF_FFF7, 4'h2);
      mul(ismu_pkg::ISMU_OP_MUL_WORD, 3'h6, 32'h8000_0000, 32'hFFFF_FFFF,
          64'h0000_0000_8000_0000, 4'h4);
   endtask
   task automatic t_overflow_irq();
      @(posedge clk);
      imask <= 1'b1;
      wr(3'h1, 32'h8000_0000);
      run(ismu_pkg::ISMU_OP_SUB_WORD, 3'h1, 3'h0, 32'h0000_0001, Z, Z);
      check(32'(flags), 32'h0000_000C);
      reg_is(3'h1, 32'h7FFF_FFFF);
      check(32'(irq), 32'h0000_0001);
      @(posedge clk);
      iclr <= 1'b1;
      @(posedge clk);
      iclr <= 1'b0;
      imask <= 1'b0;
      run(ismu_pkg::ISMU_OP_SUB_WORD, 3'h1, 3'h0, 32'hFFFF_FFFF, Z, Z);
      check(32'(flags), 32'h0000_000A);
      check(32'(irq), Z);
      @(posedge clk);
      imask <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check(32'(irq), 32'h0000_0001);
      wr(3'h6, 32'h7FFF_FFFF);
      wr(3'h7, 32'hFFFF_FFFF);
      run(ismu_pkg::ISMU_OP_SUB_DOUBLE, 3'h6, 3'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, Z);
      check(32'(flags), 32'h0000_000A);
      reg_is(3'h6, 32'h8000_0000);
      reg_is(3'h7, Z);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_sub_single();
      t_sub_regs();
      t_mul();
      t_overflow_irq();
      wrap_up();
   end
endmodule
bind ismu_core ismu_core_properties i_ismu_core_properties (.core_clk_i, .sys_rst_i,
   .start_i, .req_i, .reg_wr_en_i, .reg_wr_idx_i, .reg_wr_data_i, .reg_rd_idx_i,
   .irq_clear_i, .irq_mask_i, .reg_rd_data_o, .busy_o, .done_o, .cond_flags_o, .irq_o);
`default_nettype wire
